// >>> hw/tks_pkg.sv
// package: register map, field layout, reset values and types of the touch scan block
package tks_pkg;
    localparam int NUM_MOD = 5; // touch key modules
    localparam int KEYS_PER_MOD = 4; // keys grouped per module
    localparam int NUM_KEY = NUM_MOD * KEYS_PER_MOD; // total keys
    localparam int ADDR_W = 12; // apb address width
    // register byte offsets
    localparam logic [11:0] OFF_GLOBAL = 12'h000; // touch_global_ctrl
    localparam logic [11:0] OFF_PRESCALE = 12'h004; // slot_prescale_value
    localparam logic [11:0] OFF_MOD_CTRL = 12'h010; // pin/osc ctrl, 4 per module
    localparam logic [11:0] OFF_HOP = 12'h030; // hop select, 4 per module
    localparam logic [11:0] OFF_CNT16 = 12'h050; // 16-bit counter per module
    localparam logic [11:0] OFF_SENSE = 12'h080; // sense counter per key
    // touch_global_ctrl fields
    localparam int GC_DIV_LSB = 0; // counter_clock_divide, 2 bits
    localparam int GC_SHARED_BIT = 2; // shared_slot_select
    localparam int GC_START_BIT = 5; // scan_start
    localparam int GC_OVF_BIT = 6; // slot_overflow_flag
    // touch_module_pin_osc_ctrl fields
    localparam int MC_SLOT_CLK_BIT = 7; // slot_clock_select
    localparam int MC_UNUSED_BIT = 6; // unimplemented, reads zero
    localparam int MC_REF_EN_BIT = 5; // reference_osc_enable
    localparam int MC_SENSE_EN_BIT = 4; // sense_osc_enable
    // reset values
    localparam logic [7:0] RST_GLOBAL = 8'h00;
    localparam logic [7:0] RST_PRESCALE = 8'h00;
    localparam logic [7:0] RST_MOD_CTRL = 8'h00;
    localparam logic [2:0] RST_HOP = 3'h0;
    // timing: slot clock from system clock divided by four
    localparam logic [2:0] SYS_DIV4_MASK = 3'h3;
    localparam logic [4:0] SLOT_LAST = 5'h1f; // 5-bit slot counter top
    localparam logic [7:0] PRE_LAST = 8'hff; // 8-bit prescaler top

    // per-module control register layout
    typedef struct packed {
        logic slot_clock_select; // 1: sys/4, 0: reference osc
        logic unused; // always zero
        logic reference_osc_enable;
        logic sense_osc_enable;
        logic [3:0] pin_function_select; // 1: touch, 0: gpio
    } tks_mod_ctrl_t;

    // apb request carrier
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } tks_apb_req_t;
endpackage

// >>> hw/tks_top.sv
// touch key scan controller: apb registers, slot timing chain and counters
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - three-bit hop code per module drives oscillators
// - bit7 picks slot clock: reference or sys/4
// - bit5 enables module reference oscillator
// - bit4 enables module key sense oscillators
// - bits3-0 route each pin gpio or touch
// - bit6 unimplemented, always reads zero
// - shared select makes module0 slot rule all
// - start low clears counters, keeps prescaler
// - start rising edge switches on all counters
// - slot overflow stops oscillators and counters
// - slot chain is 8-bit prescaler plus 5-bit
// - one interrupt on module0 or all enabled overflow
// - interrupt overflow clears slot chain automatically
// - four keys per module, modules identical
// - each key has own counted sense oscillator
// - start edge syncs oscillators, intervals begin together
// - interval is (256 - value) times 32 ticks
// - counter clock sys divided by 1,2,4,8
module tks_top
    import tks_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RESET_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic [NUM_MOD-1:0] REF_OSC_IN,
    input wire logic [NUM_KEY-1:0] SENSE_OSC_IN,
    output logic [NUM_MOD-1:0] REF_OSC_EN_OUT,
    output logic [NUM_MOD-1:0] SENSE_OSC_EN_OUT,
    output logic [NUM_KEY-1:0] PIN_TOUCH_SEL_OUT,
    output logic [3*NUM_MOD-1:0] HOP_FREQ_OUT,
    output logic TOUCH_IRQ_OUT
);
    // word index of an address inside a block of registers
    function automatic logic [4:0] reg_idx(input logic [11:0] a,
                                           input logic [11:0] base);
        logic [11:0] d;
        d = a - base;
        reg_idx = d[6:2];
    endfunction

    // in-range test for an array of word registers
    function automatic logic in_blk(input logic [11:0] a,
                                    input logic [11:0] base,
                                    input int n);
        logic [11:0] top;
        top = base + 12'(n * 4);
        in_blk = (a >= base) && (a < top) && (a[1:0] == 2'h0);
    endfunction

    tks_apb_req_t req; // bundled apb request
    assign req = '{sel: PSEL_IN, enable: PENABLE_IN, write: PWRITE_IN,
                   addr: PADDR_IN, wdata: PWDATA_IN};

    // software-visible registers
    logic [1:0] div_sel_ff; // counter_clock_divide
    logic shared_ff; // shared_slot_select
    logic start_ff; // scan_start
    logic ovf_flag_ff; // slot_overflow_flag
    logic [7:0] prescale_ff; // slot_prescale_value
    tks_mod_ctrl_t mod_ctrl_ff [NUM_MOD]; // per-module pin/osc ctrl
    logic [2:0] hop_ff [NUM_MOD]; // hop_freq_select
    // timing and measurement state
    logic start_d_ff; // start delayed for edge detect
    logic run_ff; // scan in progress
    logic [NUM_MOD-1:0] mod_done_ff; // module slot overflowed
    logic [7:0] pre_ff [NUM_MOD]; // 8-bit slot prescaler
    logic [4:0] slot_ff [NUM_MOD]; // 5-bit slot counter
    logic [15:0] cnt16_ff [NUM_MOD]; // 16-bit counter
    logic [15:0] sense_ff [NUM_KEY]; // per-key sense counter
    logic [2:0] div_ff; // free-running system clock divider
    // pin synchronisers
    logic [NUM_MOD-1:0] ref_s1_ff, ref_s2_ff, ref_s3_ff;
    logic [NUM_KEY-1:0] key_s1_ff, key_s2_ff, key_s3_ff;
    // apb read path
    logic [31:0] rdata_ff;
    logic slverr_ff;

    // decode of the current address
    wire is_global = (req.addr == OFF_GLOBAL);
    wire is_pre = (req.addr == OFF_PRESCALE);
    wire is_mod = in_blk(req.addr, OFF_MOD_CTRL, NUM_MOD);
    wire is_hop = in_blk(req.addr, OFF_HOP, NUM_MOD);
    wire is_c16 = in_blk(req.addr, OFF_CNT16, NUM_MOD);
    wire is_sense = in_blk(req.addr, OFF_SENSE, NUM_KEY);
    wire hit = is_global | is_pre | is_mod | is_hop | is_c16 | is_sense;
    wire [4:0] idx_mod = reg_idx(req.addr, OFF_MOD_CTRL);
    wire [4:0] idx_hop = reg_idx(req.addr, OFF_HOP);
    wire [4:0] idx_c16 = reg_idx(req.addr, OFF_CNT16);
    wire [4:0] idx_sense = reg_idx(req.addr, OFF_SENSE);
    wire setup = req.sel & ~req.enable; // first apb cycle
    wire wr = req.sel & req.enable & req.write; // write takes effect
    wire wr_global = wr & is_global;

    // event strobes
    wire start_rise = start_ff & ~start_d_ff; // scan begins
    wire [NUM_MOD-1:0] ref_edge = ref_s2_ff & ~ref_s3_ff;
    wire [NUM_KEY-1:0] key_edge = key_s2_ff & ~key_s3_ff;
    wire sys4_tick = ((div_ff & SYS_DIV4_MASK) == 3'h0);
    // 16-bit counter clock: sys, /2, /4, /8
    wire c16_tick = (div_sel_ff == 2'h0) ? 1'b1 :
                    (div_sel_ff == 2'h1) ? (div_ff[0] == 1'b0) :
                    (div_sel_ff == 2'h2) ? (div_ff[1:0] == 2'h0) :
                    (div_ff == 3'h0);

    // per-module slot tick, wrap and overflow
    logic [NUM_MOD-1:0] slot_tick, pre_wrap, own_ovf, mod_en, mod_run;
    always_comb begin
        for (int n = 0; n < NUM_MOD; n++) begin
            // slot clock source
            slot_tick[n] = mod_ctrl_ff[n].slot_clock_select ? sys4_tick
                                                            : ref_edge[n];
            pre_wrap[n] = slot_tick[n] & (pre_ff[n] == PRE_LAST);
            // 32 prescaler wraps end the slot
            own_ovf[n] = pre_wrap[n] & (slot_ff[n] == SLOT_LAST)
                         & run_ff & ~mod_done_ff[n];
            mod_en[n] = mod_ctrl_ff[n].reference_osc_enable
                        | mod_ctrl_ff[n].sense_osc_enable;
            // shared mode: every module measures over module 0
            mod_run[n] = run_ff & (shared_ff | ~mod_done_ff[n]);
        end
    end

    // interrupt-raising overflow: module 0, or all enabled
    wire all_done = &(mod_done_ff | own_ovf | ~mod_en);
    wire scan_done = run_ff & (shared_ff ? own_ovf[0] : all_done);

    // divider and synchronisers, two flops before use
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            div_ff <= 3'h0;
            ref_s1_ff <= '0;
            ref_s2_ff <= '0;
            ref_s3_ff <= '0;
            key_s1_ff <= '0;
            key_s2_ff <= '0;
            key_s3_ff <= '0;
        end else begin
            div_ff <= div_ff + 3'h1;
            ref_s1_ff <= REF_OSC_IN;
            ref_s2_ff <= ref_s1_ff;
            ref_s3_ff <= ref_s2_ff;
            key_s1_ff <= SENSE_OSC_IN;
            key_s2_ff <= key_s1_ff;
            key_s3_ff <= key_s2_ff;
        end
    end

    // global control register and overflow flag
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            div_sel_ff <= RST_GLOBAL[GC_DIV_LSB +: 2];
            shared_ff <= RST_GLOBAL[GC_SHARED_BIT];
            start_ff <= RST_GLOBAL[GC_START_BIT];
            ovf_flag_ff <= RST_GLOBAL[GC_OVF_BIT];
            prescale_ff <= RST_PRESCALE;
        end else begin
            if (wr_global) begin
                div_sel_ff <= req.wdata[GC_DIV_LSB +: 2];
                shared_ff <= req.wdata[GC_SHARED_BIT];
                // scan only starts on a zero-to-one write
                start_ff <= req.wdata[GC_START_BIT];
            end
            // set by overflow wins over a software clear
            if (scan_done) begin
                ovf_flag_ff <= 1'b1;
            end else if (wr_global) begin
                ovf_flag_ff <= req.wdata[GC_OVF_BIT];
            end
            if (wr & is_pre) begin
                prescale_ff <= req.wdata[7:0];
            end
        end
    end

    // per-module configuration registers
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            for (int n = 0; n < NUM_MOD; n++) begin
                mod_ctrl_ff[n] <= tks_mod_ctrl_t'(RST_MOD_CTRL);
                hop_ff[n] <= RST_HOP;
            end
        end else begin
            for (int n = 0; n < NUM_MOD; n++) begin
                if (wr & is_mod & (idx_mod == 5'(n))) begin
                    mod_ctrl_ff[n] <= tks_mod_ctrl_t'(req.wdata[7:0]);
                    mod_ctrl_ff[n].unused <= 1'b0;
                end
                if (wr & is_hop & (idx_hop == 5'(n))) begin
                    hop_ff[n] <= req.wdata[2:0];
                end
            end
        end
    end

    // scan run state
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            start_d_ff <= 1'b0;
            run_ff <= 1'b0;
            mod_done_ff <= '0;
        end else begin
            start_d_ff <= start_ff;
            if (~start_ff) begin
                run_ff <= 1'b0; // held idle while start is low
                mod_done_ff <= '0;
            end else if (start_rise) begin
                run_ff <= 1'b1; // all modules start together
                mod_done_ff <= '0;
            end else if (scan_done) begin
                run_ff <= 1'b0; // everything switched off
            end else begin
                mod_done_ff <= mod_done_ff | own_ovf;
            end
        end
    end

    // 8+5 slot timing chain per module
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            for (int n = 0; n < NUM_MOD; n++) begin
                pre_ff[n] <= 8'h00;
                slot_ff[n] <= 5'h00;
            end
        end else begin
            for (int n = 0; n < NUM_MOD; n++) begin
                if (~start_ff) begin
                    slot_ff[n] <= 5'h00; // prescaler keeps value
                end else if (start_rise) begin
                    pre_ff[n] <= prescale_ff;
                    slot_ff[n] <= 5'h00;
                end else if (scan_done) begin
                    pre_ff[n] <= 8'h00; // auto clear
                    slot_ff[n] <= 5'h00;
                end else if (run_ff & ~mod_done_ff[n] & slot_tick[n]) begin
                    // prescaler counts value..255 then steps slot
                    if (pre_wrap[n]) begin
                        pre_ff[n] <= prescale_ff;
                        slot_ff[n] <= slot_ff[n] + 5'h01;
                    end else begin
                        pre_ff[n] <= pre_ff[n] + 8'h01;
                    end
                end
            end
        end
    end

    // 16-bit counters and per-key sense counters
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            for (int n = 0; n < NUM_MOD; n++) begin
                cnt16_ff[n] <= 16'h0000;
            end
            for (int k = 0; k < NUM_KEY; k++) begin
                sense_ff[k] <= 16'h0000;
            end
        end else begin
            for (int n = 0; n < NUM_MOD; n++) begin
                if (~start_ff | start_rise) begin
                    cnt16_ff[n] <= 16'h0000;
                end else if (mod_run[n] & c16_tick) begin
                    cnt16_ff[n] <= cnt16_ff[n] + 16'h0001;
                end
                // no increment after the scan ends: values hold
            end
            // key k lives in module k/4, identical per module
            for (int k = 0; k < NUM_KEY; k++) begin
                if (~start_ff | start_rise) begin
                    sense_ff[k] <= 16'h0000;
                end else if (mod_run[k / KEYS_PER_MOD] & key_edge[k]
                             & mod_ctrl_ff[k / KEYS_PER_MOD].sense_osc_enable
                             & mod_ctrl_ff[k / KEYS_PER_MOD]
                               .pin_function_select[k % KEYS_PER_MOD]) begin
                    sense_ff[k] <= sense_ff[k] + 16'h0001;
                end
            end
        end
    end

    // read data mux, registered in the setup cycle
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (is_global) begin
            rd_mux[GC_DIV_LSB +: 2] = div_sel_ff;
            rd_mux[GC_SHARED_BIT] = shared_ff;
            rd_mux[GC_START_BIT] = start_ff;
            rd_mux[GC_OVF_BIT] = ovf_flag_ff;
        end else if (is_pre) begin
            rd_mux[7:0] = prescale_ff;
        end else if (is_mod) begin
            rd_mux[7:0] = mod_ctrl_ff[idx_mod[2:0]]; // bit 6 zero
        end else if (is_hop) begin
            rd_mux[2:0] = hop_ff[idx_hop[2:0]];
        end else if (is_c16) begin
            rd_mux[15:0] = cnt16_ff[idx_c16[2:0]];
        end else if (is_sense) begin
            rd_mux[15:0] = sense_ff[idx_sense];
        end
    end

    // apb answer: ready in the access cycle, error on unmapped
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            rdata_ff <= 32'h0000_0000;
            slverr_ff <= 1'b0;
        end else if (setup) begin
            rdata_ff <= req.write ? 32'h0000_0000 : rd_mux;
            slverr_ff <= ~hit;
        end
    end

    assign PRDATA_OUT = rdata_ff;
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = req.sel & req.enable & slverr_ff;
    assign TOUCH_IRQ_OUT = ovf_flag_ff; // single touch interrupt

    // oscillator enables and pin routing
    always_comb begin
        for (int n = 0; n < NUM_MOD; n++) begin
            // oscillators run only inside the scan
            REF_OSC_EN_OUT[n] = mod_ctrl_ff[n].reference_osc_enable
                                & mod_run[n];
            SENSE_OSC_EN_OUT[n] = mod_ctrl_ff[n].sense_osc_enable
                                  & mod_run[n];
            PIN_TOUCH_SEL_OUT[n*KEYS_PER_MOD +: KEYS_PER_MOD] =
                mod_ctrl_ff[n].pin_function_select;
            HOP_FREQ_OUT[n*3 +: 3] = hop_ff[n];
        end
    end
endmodule

`default_nettype wire

// >>> test/tks_top_props.sv
// checker: port-level properties of the touch scan controller
`timescale 1ns/100ps
`default_nettype none
module tks_top_props
    import tks_pkg::*;
(
    input wire logic REF_CLK_IN,
    input wire logic RESET_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire logic [NUM_MOD-1:0] REF_OSC_EN_OUT,
    input wire logic [NUM_MOD-1:0] SENSE_OSC_EN_OUT,
    input wire logic [NUM_KEY-1:0] PIN_TOUCH_SEL_OUT,
    input wire logic [3*NUM_MOD-1:0] HOP_FREQ_OUT,
    input wire logic TOUCH_IRQ_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RESET_IN);
    // write access to the global control word
    wire logic glob_wr = PSEL_IN & PENABLE_IN & PWRITE_IN
        & (PADDR_IN == OFF_GLOBAL);
    // all oscillator enables are off
    wire logic osc_off = (REF_OSC_EN_OUT == '0) && (SENSE_OSC_EN_OUT == '0);
    // access phase at one address
    sequence s_acc(logic [11:0] a);
        PSEL_IN && PENABLE_IN && (PADDR_IN == a);
    endsequence
    // write access phase at one address
    sequence s_wr(logic [11:0] a);
        s_acc(a) ##0 PWRITE_IN;
    endsequence
    property p_ready; PREADY_OUT; endproperty
    property p_err; s_acc(12'h008) |-> PSLVERR_OUT; endproperty
    property p_noerr; s_acc(OFF_GLOBAL) |-> !PSLVERR_OUT; endproperty
    property p_idle; !PSEL_IN |-> !PSLVERR_OUT; endproperty
    property p_hop;
        s_wr(OFF_HOP) |=> HOP_FREQ_OUT[2:0] == $past(PWDATA_IN[2:0]);
    endproperty
    property p_pins;
        s_wr(OFF_MOD_CTRL) |=> PIN_TOUCH_SEL_OUT[3:0] == $past(PWDATA_IN[3:0]);
    endproperty
    property p_rsv;
        s_acc(OFF_MOD_CTRL) ##0 !PWRITE_IN |-> PRDATA_OUT[6] == 1'b0;
    endproperty
    property p_hold;
        TOUCH_IRQ_OUT && !(glob_wr && !PWDATA_IN[GC_OVF_BIT])
            |=> TOUCH_IRQ_OUT;
    endproperty
    property p_clr;
        TOUCH_IRQ_OUT && glob_wr && !PWDATA_IN[GC_OVF_BIT] && osc_off
            |=> !TOUCH_IRQ_OUT;
    endproperty
    property p_ovf; $rose(TOUCH_IRQ_OUT) |-> osc_off; endproperty
    property p_stop;
        glob_wr && !PWDATA_IN[GC_START_BIT] |-> ##[1:3] osc_off;
    endproperty
    a_ready: assert property (p_ready) else $error("ready low");
    a_err: assert property (p_err) else $error("no error on hole");
    a_noerr: assert property (p_noerr) else $error("error on global");
    a_idle: assert property (p_idle) else $error("error while idle");
    a_hop: assert property (p_hop) else $error("hop code wrong");
    a_pins: assert property (p_pins) else $error("pin route wrong");
    a_rsv: assert property (p_rsv) else $error("bit six set");
    a_hold: assert property (p_hold) else $error("irq dropped");
    a_clr: assert property (p_clr) else $error("irq stuck");
    a_ovf: assert property (p_ovf) else $error("osc on at done");
    a_stop: assert property (p_stop) else $error("osc on at stop");
endmodule
`default_nettype wire

// >>> test/tks_pad_model.sv
// model: touch pads with per-key sense and per-module reference oscillators
`timescale 1ns/100ps
`default_nettype none
module tks_pad_model
    import tks_pkg::*;
(
    input wire logic clk_in,
    input wire logic [NUM_MOD-1:0] ref_en_in,
    input wire logic [NUM_MOD-1:0] sense_en_in,
    output logic [NUM_MOD-1:0] ref_osc_out,
    output logic [NUM_KEY-1:0] sense_osc_out
);
    int ref_cnt[NUM_MOD]; // half-period counters, reference
    int sense_cnt[NUM_KEY]; // half-period counters, keys
    initial begin
        ref_osc_out = '0;
        sense_osc_out = '0;
    end
    // oscillators run only while enabled and rest low otherwise
    always @(posedge clk_in) begin
        for (int m = 0; m < NUM_MOD; m++) begin
            ref_cnt[m] = ref_en_in[m] ? ref_cnt[m] + 1 : 0;
            if (!ref_en_in[m]) ref_osc_out[m] <= 1'b0;
            else if (ref_cnt[m] % (3 + 2 * m) == 0)
                ref_osc_out[m] <= ~ref_osc_out[m];
        end
        // one oscillator per key, key k sits in module k/4
        for (int k = 0; k < NUM_KEY; k++) begin
            sense_cnt[k] = sense_en_in[k / 4] ? sense_cnt[k] + 1 : 0;
            if (!sense_en_in[k / 4]) sense_osc_out[k] <= 1'b0;
            else if (sense_cnt[k] % 4 == 0)
                sense_osc_out[k] <= ~sense_osc_out[k];
        end
    end
endmodule
`default_nettype wire

// >>> test/tks_top_tb.sv
// testbench: registers, scan timing and readout of the touch scan block
`timescale 1ns/100ps
`default_nettype none
module tks_top_tb
    import tks_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq;
    wire logic [NUM_MOD-1:0] ref_osc, ref_en, sense_en;
    wire logic [NUM_KEY-1:0] sense_osc, pin_sel;
    wire logic [3*NUM_MOD-1:0] hop;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] rd; // last read data
    logic err; // last error response
    tks_top i_tks_top (.REF_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .REF_OSC_IN(ref_osc), .SENSE_OSC_IN(sense_osc),
        .REF_OSC_EN_OUT(ref_en), .SENSE_OSC_EN_OUT(sense_en),
        .PIN_TOUCH_SEL_OUT(pin_sel), .HOP_FREQ_OUT(hop), .TOUCH_IRQ_OUT(irq));
    tks_pad_model i_tks_pad_model (.clk_in(clk), .ref_en_in(ref_en),
        .sense_en_in(sense_en), .ref_osc_out(ref_osc),
        .sense_osc_out(sense_osc));
    always #20 clk = ~clk;
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        $display("tests=%0d failures=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_rng(input logic [31:0] got, input int lo,
            input int hi);
        n_tests++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h lo=%h hi=%h", $time, got,
                lo, hi);
        end
    endtask
    // one apb transfer, setup then access until ready
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic t_reset_vals;
        apb(1'b0, OFF_GLOBAL, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, OFF_PRESCALE, 32'h0);
        check(rd, 32'h0);
        for (int n = 0; n < NUM_MOD; n++) begin
            apb(1'b0, OFF_MOD_CTRL + 12'(4 * n), 32'h0);
            check(rd, 32'h0);
            apb(1'b0, OFF_HOP + 12'(4 * n), 32'h0);
            check(rd, 32'h0);
        end
    endtask
    task automatic t_regs;
        logic [3:0] nib;
        for (int n = 0; n < NUM_MOD; n++) begin
            nib = 4'(3 * n);
            apb(1'b1, OFF_MOD_CTRL + 12'(4 * n), 32'hffff_ffc0 | 32'(nib));
            apb(1'b0, OFF_MOD_CTRL + 12'(4 * n), 32'h0);
            check(rd, 32'h80 | 32'(nib));
            check(32'(pin_sel[4 * n +: 4]), 32'(nib));
            for (int c = 0; c < 8; c++) begin
                apb(1'b1, OFF_HOP + 12'(4 * n), 32'hffff_fff8 | 32'(c));
                @(negedge clk);
                check(32'(hop[3 * n +: 3]), 32'(c));
            end
            apb(1'b1, OFF_MOD_CTRL + 12'(4 * n), 32'h0);
        end
        apb(1'b0, 12'h008, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, OFF_SENSE, 32'hffff_ffff);
        check({31'h0, err}, 32'h0);
        apb(1'b0, OFF_SENSE, 32'h0);
        check(rd, 32'h0);
    endtask
    // restart a scan and count cycles until the interrupt
    task automatic run_scan(input logic [31:0] gc, input logic [4:0] en,
            input logic [4:0] ken, output int n);
        apb(1'b1, OFF_GLOBAL, gc);
        apb(1'b1, OFF_GLOBAL, gc | 32'h20);
        repeat (4) @(posedge clk);
        n = 4;
        check(32'(ref_en), 32'(en));
        check(32'(sense_en), 32'(ken));
        while (irq !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        @(negedge clk);
        check(32'(ref_en | sense_en), 32'h0);
    endtask
    task automatic t_sys4;
        int n;
        apb(1'b1, OFF_PRESCALE, 32'hff);
        apb(1'b1, OFF_MOD_CTRL, 32'hbf);
        for (int dv = 0; dv < 4; dv++) begin
            run_scan(32'h4 | 32'(dv), 5'h01, 5'h01, n);
            check_rng(32'(n), 126, 140);
            apb(1'b0, OFF_CNT16, 32'h0);
            check_rng(rd, 124 >> dv, (140 >> dv) + 1);
            apb(1'b0, OFF_SENSE, 32'h0);
            check_rng(rd, 13, 18);
            repeat (20) @(posedge clk);
            apb(1'b0, OFF_SENSE, 32'h0);
            check_rng(rd, 13, 18);
            apb(1'b0, OFF_SENSE + 12'h010, 32'h0);
            check(rd, 32'h0);
            apb(1'b0, OFF_GLOBAL, 32'h0);
            check(rd, 32'h64 | 32'(dv));
            apb(1'b1, OFF_GLOBAL, 32'h4 | 32'(dv));
            @(negedge clk);
            check({31'h0, irq}, 32'h0);
            apb(1'b0, OFF_SENSE, 32'h0);
            check(rd, 32'h0);
            apb(1'b0, OFF_CNT16, 32'h0);
            check(rd, 32'h0);
            apb(1'b0, OFF_PRESCALE, 32'h0);
            check(rd, 32'hff);
        end
    endtask
    task automatic t_ref;
        int n;
        apb(1'b1, OFF_PRESCALE, 32'hfe);
        apb(1'b1, OFF_MOD_CTRL, 32'h30);
        apb(1'b1, OFF_MOD_CTRL + 12'h004, 32'h20);
        run_scan(32'h4, 5'h03, 5'h01, n);
        check_rng(32'(n), 374, 404);
        run_scan(32'h0, 5'h03, 5'h01, n);
        check_rng(32'(n), 626, 664);
        apb(1'b0, OFF_SENSE, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, OFF_SENSE + 12'h010, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, OFF_GLOBAL, 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset_vals();
        t_regs();
        t_sys4();
        t_ref();
        print_verdict();
    end
endmodule
bind tks_top tks_top_props i_tks_top_props (.REF_CLK_IN(REF_CLK_IN),
    .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
    .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .REF_OSC_EN_OUT(REF_OSC_EN_OUT),
    .SENSE_OSC_EN_OUT(SENSE_OSC_EN_OUT),
    .PIN_TOUCH_SEL_OUT(PIN_TOUCH_SEL_OUT), .HOP_FREQ_OUT(HOP_FREQ_OUT),
    .TOUCH_IRQ_OUT(TOUCH_IRQ_OUT));
`default_nettype wire
